// ==== bench/framer_dl_asserts.sv ====
// Port-level assertions for the datalink and receive line configuration block.
`timescale 1ns/1ps
module framer_dl_asserts #(
    parameter NUM_FRAMERS = 4
) (
    // Clock, reset and APB.
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Line, datalink and interrupt signals.
    input wire [NUM_FRAMERS-1:0] rx_bit_strobe,
    input wire [NUM_FRAMERS-1:0] rx_line_code_violation,
    input wire [NUM_FRAMERS-1:0] rx_hdlc_data_irq,
    input wire [NUM_FRAMERS-1:0] rx_hdlc_eom_irq,
    input wire [NUM_FRAMERS-1:0] tx_hdlc_service_irq,
    input wire [NUM_FRAMERS-1:0] tx_hdlc_underrun_irq,
    input wire [NUM_FRAMERS-1:0] tx_dl_service_pin_oe,
    input wire [NUM_FRAMERS-1:0] tx_dl_underrun_pin_oe,
    input wire [NUM_FRAMERS-1:0] tx_fdl_bit_valid,
    input wire other_irq_in,
    input wire cpu_interrupt_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // The access phase of a transfer, before and at its answer.
    sequence acc_wait;
        psel && penable && !pready;
    endsequence
    sequence acc_done;
        psel && penable && pready;
    endsequence
    wait_state_a: assert property (psel && !penable ##1 acc_wait |=> acc_done)
        else $error("answer not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    irq_other_a: assert property (other_irq_in |=> cpu_interrupt_out)
        else $error("other source not on interrupt");
    irq_quiet_a: assert property (!other_irq_in && rx_hdlc_data_irq == '0 &&
        rx_hdlc_eom_irq == '0 && tx_hdlc_service_irq == '0 && tx_hdlc_underrun_irq == '0
        |=> !cpu_interrupt_out) else $error("interrupt without a source");
    strobe_pulse_a: assert property (rx_bit_strobe[0] |=> !rx_bit_strobe[0])
        else $error("bit strobe longer than one cycle");
    lcv_strobe_a: assert property (rx_line_code_violation[0] |-> rx_bit_strobe[0])
        else $error("violation without a sampled bit");
    oe_pair_a: assert property (tx_dl_service_pin_oe[0] |-> tx_dl_underrun_pin_oe[0])
        else $error("service pin driven without underrun pin");
    valid_pulse_a: assert property (tx_fdl_bit_valid[0] |=> !tx_fdl_bit_valid[0])
        else $error("serial bit valid longer than one cycle");
endmodule // framer_dl_asserts

bind framer_datalink_and_rx_line_config framer_dl_asserts #(.NUM_FRAMERS(NUM_FRAMERS)) chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_bit_strobe(rx_bit_strobe),
    .rx_line_code_violation(rx_line_code_violation), .rx_hdlc_data_irq(rx_hdlc_data_irq),
    .rx_hdlc_eom_irq(rx_hdlc_eom_irq), .tx_hdlc_service_irq(tx_hdlc_service_irq),
    .tx_hdlc_underrun_irq(tx_hdlc_underrun_irq), .tx_dl_service_pin_oe(tx_dl_service_pin_oe),
    .tx_dl_underrun_pin_oe(tx_dl_underrun_pin_oe), .tx_fdl_bit_valid(tx_fdl_bit_valid),
    .other_irq_in(other_irq_in), .cpu_interrupt_out(cpu_interrupt_out));

// ==== bench/line_source.sv ====
// Line source model driving one framer's receive line pins and line clock.
`timescale 1ns/1ps
module line_source (
    // Receive line pins.
    output logic pos,
    output logic neg,
    output logic lclk
);
    // The clock rests low between bits.
    initial begin
        pos = 1'b0;
        neg = 1'b0;
        lclk = 1'b0;
    end
    // Places levels on the pins just after the current clock edge.
    task hold(input logic a, input logic b, input logic c);
        pos <= a;
        neg <= b;
        lclk <= c;
    endtask
    // Sends one bit in a 200 ns period, data stable well before and after both edges.
    task send(input logic a, input logic b);
        hold(a, b, 1'b0);
        #50 lclk <= 1'b1;
        #100 lclk <= 1'b0;
        #50;
    endtask
endmodule // line_source

// ==== bench/tb_top.sv ====
// Self-checking bench for the datalink and receive line configuration block.
`timescale 1ns/1ps
module tb_top;
    // Stimulus, observed outputs and counters.
    logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] src = 4'h0;
    logic [4:0] rch = 5'h18, tch = 5'h18;
    logic b8zs = 1'b0, fdl_b = 1'b0, fdl_c = 1'b0, pcm_b = 1'b0, pcm_c = 1'b0, tx_fc = 1'b0;
    logic bp = 1'b0, svc_drv = 1'b0, udr_drv = 1'b0, oirq = 1'b0, cpu_irq;
    wire lp, ln, lc;
    wire [3:0] rec_p, rec_n, stb, lcv, dl_a, dl_b, s_out, s_oe, u_out, u_oe, fb, fv, tlb;
    int miscompares = 0, checks_done = 0, n_stb = 0, n_lcv = 0, k, j, s0, l0;
    // Two-way pins resolve to whichever party drives them.
    wire s_pin = s_oe[0] ? s_out[0] : svc_drv;
    wire u_pin = u_oe[0] ? u_out[0] : udr_drv;
    // Free-running 40 MHz clock.
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Counts sampled bits and violations of the first framer.
    always @(posedge pclk) begin
        n_stb <= n_stb + (stb[0] === 1'b1);
        n_lcv <= n_lcv + (lcv[0] === 1'b1);
    end
    framer_datalink_and_rx_line_config dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_positive_pulse_in({3'h0, lp}), .rx_negative_pulse_in({3'h0, ln}),
        .rx_line_clock_in({3'h0, lc}), .rx_b8zs_mode({3'h0, b8zs}), .rx_recovered_pos(rec_p),
        .rx_recovered_neg(rec_n), .rx_bit_strobe(stb), .rx_line_code_violation(lcv),
        .rx_hdlc_data_irq({3'h0, src[3]}), .rx_hdlc_eom_irq({3'h0, src[2]}),
        .rx_fdl_bit({3'h0, fdl_b}), .rx_fdl_clock({3'h0, fdl_c}), .rx_pcm_bit({3'h0, pcm_b}),
        .rx_pcm_clock({3'h0, pcm_c}), .rx_channel_num({15'h0, rch}), .rx_dl_irq_pin(dl_a),
        .rx_dl_end_of_message_pin(dl_b), .tx_hdlc_service_irq({3'h0, src[1]}),
        .tx_hdlc_underrun_irq({3'h0, src[0]}), .tx_fdl_clock({3'h0, tx_fc}),
        .tx_channel_num({15'h0, tch}), .backplane_tx_pcm_in({3'h0, bp}),
        .tx_dl_service_pin_in({3'h0, s_pin}), .tx_dl_service_pin_out(s_out),
        .tx_dl_service_pin_oe(s_oe), .tx_dl_underrun_pin_in({3'h0, u_pin}),
        .tx_dl_underrun_pin_out(u_out), .tx_dl_underrun_pin_oe(u_oe), .tx_fdl_bit(fb),
        .tx_fdl_bit_valid(fv), .tx_line_bit(tlb), .other_irq_in(oirq), .cpu_interrupt_out(cpu_irq));
    line_source ls (.pos(lp), .neg(ln), .lclk(lc));
    // Byte address of a framer's options (c=0) or receive line register (c=1).
    function logic [11:0] ra(input logic [1:0] f, input logic c);
        ra = {1'b0, f, 5'h00, 1'b1, c, 2'h0};
    endfunction
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; read data and error are taken at the answering edge.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // A mark, nz spaces, then two marks of the same polarity.
    task burst(input int nz, input int dl);
        s0 = n_stb;
        l0 = n_lcv;
        ls.send(1'b1, 1'b0);
        repeat (nz) ls.send(1'b0, 1'b0);
        ls.send(1'b0, 1'b1);
        ls.send(1'b0, 1'b1);
        cyc(8);
        chk(n_stb - s0, nz + 3);
        chk(n_lcv - l0, dl);
    endtask
    task test_done;
        if (miscompares == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog against a hang.
    initial begin
        #400000;
        miscompares++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (k = 0; k < 4; k++) begin
            apb(1'b0, ra(k[1:0], 1'b0), 32'h0);
            chk(rd, 32'h0);
            apb(1'b0, ra(k[1:0], 1'b1), 32'h0);
            chk(rd, 32'h0);
            apb(1'b1, ra(k[1:0], 1'b0), 32'h11 * (k + 1));
        end
        for (k = 0; k < 4; k++) begin
            apb(1'b0, ra(k[1:0], 1'b0), 32'h0);
            chk(rd, 32'h11 * (k + 1));
        end
        apb(1'b1, ra(2'h0, 1'b1), 32'hffffffff);
        apb(1'b0, ra(2'h0, 1'b1), 32'h0);
        chk(rd, 32'h3f);
        apb(1'b0, 12'h010, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 12'h010, 32'h0);
        chk(er, 1'b1);
        for (k = 0; k < 4; k++) begin
            apb(1'b1, ra(2'h0, 1'b0), 32'h1 << k);
            for (j = 0; j < 4; j++) begin
                src <= 4'h1 << j;
                cyc(3);
                chk(cpu_irq, (j == k) || (k == 3 && j == 2));
            end
            src <= 4'h0;
        end
        oirq <= 1'b1;
        cyc(3);
        chk(cpu_irq, 1'b1);
        oirq <= 1'b0;
        // Receive datalink pins in DMA, serial and fractional modes.
        apb(1'b1, ra(2'h0, 1'b0), 32'h80);
        src <= 4'h8;
        cyc(3);
        chk({dl_a[0], dl_b[0]}, 2'h2);
        src <= 4'h4;
        cyc(3);
        chk({dl_a[0], dl_b[0]}, 2'h3);
        src <= 4'h0;
        fdl_b <= 1'b1;
        apb(1'b1, ra(2'h0, 1'b0), 32'h0);
        cyc(2);
        chk({dl_a[0], dl_b[0]}, 2'h2);
        fdl_b <= 1'b0;
        fdl_c <= 1'b1;
        cyc(3);
        chk({dl_a[0], dl_b[0]}, 2'h1);
        pcm_b <= 1'b1;
        pcm_c <= 1'b1;
        apb(1'b1, ra(2'h0, 1'b0), 32'hc0);
        cyc(2);
        chk({dl_a[0], dl_b[0]}, 2'h3);
        rch <= 5'h17;
        cyc(3);
        chk(dl_b[0], 1'b0);
        // Transmit datalink pins in DMA, serial and fractional modes.
        apb(1'b1, ra(2'h0, 1'b0), 32'h20);
        src <= 4'h3;
        cyc(3);
        chk({s_oe[0], s_out[0], u_oe[0], u_out[0]}, 4'hf);
        src <= 4'h0;
        svc_drv <= 1'b1;
        apb(1'b1, ra(2'h0, 1'b0), 32'h0);
        cyc(4);
        tx_fc <= 1'b1;
        cyc(5);
        chk({s_oe[0], u_oe[0], u_out[0], fb[0]}, 4'h7);
        apb(1'b1, ra(2'h0, 1'b0), 32'h10);
        cyc(4);
        udr_drv <= 1'b1;
        cyc(6);
        chk({s_oe[0], u_oe[0], tlb[0]}, 3'h1);
        tch <= 5'h17;
        cyc(3);
        chk(tlb[0], 1'b0);
        // Receive line sampling and violation counting.
        apb(1'b1, ra(2'h0, 1'b1), 32'h0);
        burst(15, 1);
        burst(16, 2);
        apb(1'b1, ra(2'h0, 1'b1), 32'h20);
        burst(16, 1);
        b8zs <= 1'b1;
        apb(1'b1, ra(2'h0, 1'b1), 32'h0);
        burst(7, 1);
        burst(8, 2);
        b8zs <= 1'b0;
        apb(1'b1, ra(2'h0, 1'b1), 32'h18);
        ls.send(1'b0, 1'b0);
        cyc(6);
        chk({rec_p[0], rec_n[0]}, 2'h3);
        apb(1'b1, ra(2'h0, 1'b1), 32'h04);
        l0 = n_lcv;
        ls.send(1'b1, 1'b1);
        cyc(6);
        chk({rec_p[0], rec_n[0], n_lcv - l0 == 1}, 3'h5);
        apb(1'b1, ra(2'h0, 1'b1), 32'h02);
        s0 = n_stb;
        ls.hold(1'b0, 1'b0, 1'b1);
        cyc(8);
        chk(n_stb - s0, 0);
        ls.hold(1'b0, 1'b0, 1'b0);
        cyc(8);
        chk(n_stb - s0, 1);
        apb(1'b1, ra(2'h0, 1'b1), 32'h01);
        s0 = n_stb;
        ls.hold(1'b1, 1'b0, 1'b1);
        cyc(8);
        chk(rec_p[0], 1'b1);
        ls.hold(1'b0, 1'b0, 1'b0);
        cyc(8);
        chk({rec_p[0], n_stb - s0 == 0}, 2'h1);
        test_done();
    end
endmodule // tb_top

// ==== design/framer_datalink_and_rx_line_config.v ====
// Datalink pin routing, interrupt steering and receive line sampling for four framers.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "framer_dl_regs.vh"

module framer_datalink_and_rx_line_config #(
    parameter NUM_FRAMERS = 4,
    parameter [23:0] RX_CHAN_SEL = `CHAN_SEL_DEFAULT,
    parameter [23:0] TX_CHAN_SEL = `CHAN_SEL_DEFAULT
) (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`APB_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Receive line pins, asynchronous.
    input wire [NUM_FRAMERS-1:0] rx_positive_pulse_in,
    input wire [NUM_FRAMERS-1:0] rx_negative_pulse_in,
    input wire [NUM_FRAMERS-1:0] rx_line_clock_in,
    input wire [NUM_FRAMERS-1:0] rx_b8zs_mode,
    // Receive line results toward clock recovery and the counters.
    output wire [NUM_FRAMERS-1:0] rx_recovered_pos,
    output wire [NUM_FRAMERS-1:0] rx_recovered_neg,
    output wire [NUM_FRAMERS-1:0] rx_bit_strobe,
    output wire [NUM_FRAMERS-1:0] rx_line_code_violation,
    // Receive HDLC engine and framer sources, same clock.
    input wire [NUM_FRAMERS-1:0] rx_hdlc_data_irq,
    input wire [NUM_FRAMERS-1:0] rx_hdlc_eom_irq,
    input wire [NUM_FRAMERS-1:0] rx_fdl_bit,
    input wire [NUM_FRAMERS-1:0] rx_fdl_clock,
    input wire [NUM_FRAMERS-1:0] rx_pcm_bit,
    input wire [NUM_FRAMERS-1:0] rx_pcm_clock,
    input wire [NUM_FRAMERS*5-1:0] rx_channel_num,
    // Receive datalink pins.
    output wire [NUM_FRAMERS-1:0] rx_dl_irq_pin,
    output wire [NUM_FRAMERS-1:0] rx_dl_end_of_message_pin,
    // Transmit HDLC engine and framer sources, same clock.
    input wire [NUM_FRAMERS-1:0] tx_hdlc_service_irq,
    input wire [NUM_FRAMERS-1:0] tx_hdlc_underrun_irq,
    input wire [NUM_FRAMERS-1:0] tx_fdl_clock,
    input wire [NUM_FRAMERS*5-1:0] tx_channel_num,
    input wire [NUM_FRAMERS-1:0] backplane_tx_pcm_in,
    // Transmit datalink pins, two-way.
    input wire [NUM_FRAMERS-1:0] tx_dl_service_pin_in,
    output wire [NUM_FRAMERS-1:0] tx_dl_service_pin_out,
    output wire [NUM_FRAMERS-1:0] tx_dl_service_pin_oe,
    input wire [NUM_FRAMERS-1:0] tx_dl_underrun_pin_in,
    output wire [NUM_FRAMERS-1:0] tx_dl_underrun_pin_out,
    output wire [NUM_FRAMERS-1:0] tx_dl_underrun_pin_oe,
    // Transmit results toward the transmitter.
    output wire [NUM_FRAMERS-1:0] tx_fdl_bit,
    output wire [NUM_FRAMERS-1:0] tx_fdl_bit_valid,
    output wire [NUM_FRAMERS-1:0] tx_line_bit,
    // Interrupt.
    input wire other_irq_in,
    output wire cpu_interrupt_out
);

    // True when the channel number (1 to 24) is set in the map.
    function chan_hit;
        input [23:0] map;
        input [4:0] chan;
        begin
            chan_hit = 1'b0;
            if (chan != 5'd0 && chan <= 5'd24) begin
                chan_hit = map[chan - 5'd1];
            end
        end
    endfunction
    wire [9:0] reg_idx;
    wire apb_access;
    wire apb_write;
    wire [NUM_FRAMERS*8-1:0] dl_flat;
    wire [NUM_FRAMERS*6-1:0] rx_flat;
    wire [NUM_FRAMERS-1:0] irq_contrib;
    reg pready_ff;
    reg pslverr_ff;
    reg [31:0] prdata_ff;
    reg irq_ff;
    reg [31:0] nxt_rdata;
    reg nxt_err;
    integer k;
    // Byte address to register index; the low two address bits are ignored.
    assign reg_idx = paddr[11:2];
    assign apb_access = psel & penable;
    assign apb_write = apb_access & pwrite & pready_ff;

    // Read data and error for the addressed register.
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_err = 1'b1;
        for (k = 0; k < NUM_FRAMERS; k = k + 1) begin
            if (reg_idx == `DL_OPT_F1_IDX + k * `FRAMER_IDX_STRIDE) begin
                nxt_rdata = {24'h000000, dl_flat[k*8 +: 8]};
                nxt_err = 1'b0;
            end
            if (reg_idx == `RX_CFG_F1_IDX + k * `FRAMER_IDX_STRIDE) begin
                nxt_rdata = {26'h0000000, rx_flat[k*6 +: 6]};
                nxt_err = 1'b0;
            end
        end
    end

    // One wait state: ready rises on the second access cycle with data and error.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= apb_access & ~pready_ff;
            pslverr_ff <= apb_access & ~pready_ff & nxt_err;
            if (apb_access & ~pready_ff & ~pwrite) begin
                prdata_ff <= nxt_rdata;
            end
        end
    end

    // Interrupt output gathers every enabled framer source.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= other_irq_in | (|irq_contrib);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign cpu_interrupt_out = irq_ff;
    genvar f;
    generate
        for (f = 0; f < NUM_FRAMERS; f = f + 1) begin : g_framer
            reg [7:0] dl_opt_ff;
            reg [5:0] rx_cfg_ff;
            reg pos_s1_ff, pos_s2_ff, neg_s1_ff, neg_s2_ff;
            reg clk_s1_ff, clk_s2_ff, clk_prev_ff;
            reg last_pol_ff, seen_mark_ff;
            reg [4:0] zero_run_ff;
            reg rec_pos_ff, rec_neg_ff, strobe_ff, lcv_ff;
            reg rx_pin_a_ff, rx_pin_b_ff;
            reg svc_out_ff, svc_oe_ff, udr_out_ff, udr_oe_ff;
            reg tdat_s1_ff, tdat_s2_ff, bclk_s1_ff, bclk_s2_ff, bclk_prev_ff;
            reg fdl_clk_prev_ff, fdl_bit_ff, fdl_valid_ff, frac_bit_ff, line_bit_ff;
            wire pos_in, neg_in, mark, sample, rz_bypass, bpv, excused, exz;
            wire [4:0] exz_limit;
            wire rx_frac, rx_dma, tx_frac, tx_dma;

            assign dl_flat[f*8 +: 8] = dl_opt_ff;
            assign rx_flat[f*6 +: 6] = rx_cfg_ff;

            // Register writes land on the edge where the access completes.
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dl_opt_ff <= `DL_OPT_RESET;
                    rx_cfg_ff <= `RX_CFG_RESET;
                end else begin
                    if (apb_write && reg_idx == `DL_OPT_F1_IDX + f * `FRAMER_IDX_STRIDE) begin
                        dl_opt_ff <= pwdata[7:0];
                    end
                    if (apb_write && reg_idx == `RX_CFG_F1_IDX + f * `FRAMER_IDX_STRIDE) begin
                        rx_cfg_ff <= pwdata[5:0];
                    end
                end
            end

            // Two-stage synchronisers for the line data, line clock and transmit datalink pins; the B8ZS mode pin is used unsynchronised.
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pos_s1_ff <= 1'b0;
                    pos_s2_ff <= 1'b0;
                    neg_s1_ff <= 1'b0;
                    neg_s2_ff <= 1'b0;
                    clk_s1_ff <= 1'b0;
                    clk_s2_ff <= 1'b0;
                    tdat_s1_ff <= 1'b0;
                    tdat_s2_ff <= 1'b0;
                    bclk_s1_ff <= 1'b0;
                    bclk_s2_ff <= 1'b0;
                end else begin
                    pos_s1_ff <= rx_positive_pulse_in[f];
                    pos_s2_ff <= pos_s1_ff;
                    neg_s1_ff <= rx_negative_pulse_in[f];
                    neg_s2_ff <= neg_s1_ff;
                    clk_s1_ff <= rx_line_clock_in[f];
                    clk_s2_ff <= clk_s1_ff;
                    tdat_s1_ff <= tx_dl_service_pin_in[f];
                    tdat_s2_ff <= tdat_s1_ff;
                    bclk_s1_ff <= tx_dl_underrun_pin_in[f];
                    bclk_s2_ff <= bclk_s1_ff;
                end
            end

            // Input conditioning and edge choice for the receive line.
            assign pos_in = pos_s2_ff ^ rx_cfg_ff[`RX_POS_INV];
            assign neg_in = neg_s2_ff ^ rx_cfg_ff[`RX_NEG_INV];
            assign sample = rx_cfg_ff[`RX_FALL_EDGE] ? (~clk_s2_ff & clk_prev_ff) :
                            (clk_s2_ff & ~clk_prev_ff);
            assign rz_bypass = rx_cfg_ff[`RX_RZ_SEL] & ~rx_cfg_ff[`RX_UNIPOLAR];
            // A mark is a one on the data input, or a pulse on either rail.
            assign mark = rx_cfg_ff[`RX_UNIPOLAR] ? pos_in : (pos_in | neg_in);
            // Same polarity as the previous pulse is a bipolar violation.
            assign excused = rx_b8zs_mode[f] &
                             (zero_run_ff == `B8ZS_GAP_FIRST || zero_run_ff == `B8ZS_GAP_SECOND);
            assign bpv = ~rx_cfg_ff[`RX_UNIPOLAR] & (pos_in ^ neg_in) & seen_mark_ff &
                         (pos_in == last_pol_ff) & ~excused;
            assign exz_limit = rx_b8zs_mode[f] ? `EXZ_B8ZS_LIMIT : `EXZ_AMI_LIMIT;
            assign exz = ~mark & (zero_run_ff == exz_limit);

            // Receive line sampling, violation and excessive zero detection.
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    clk_prev_ff <= 1'b0;
                    last_pol_ff <= 1'b0;
                    seen_mark_ff <= 1'b0;
                    zero_run_ff <= 5'h00;
                    rec_pos_ff <= 1'b0;
                    rec_neg_ff <= 1'b0;
                    strobe_ff <= 1'b0;
                    lcv_ff <= 1'b0;
                end else begin
                    clk_prev_ff <= clk_s2_ff;
                    strobe_ff <= 1'b0;
                    lcv_ff <= 1'b0;
                    if (rz_bypass) begin
                        rec_pos_ff <= pos_in;
                        rec_neg_ff <= neg_in;
                    end else if (sample) begin
                        strobe_ff <= 1'b1;
                        rec_pos_ff <= pos_in;
                        rec_neg_ff <= rx_cfg_ff[`RX_UNIPOLAR] ? 1'b0 : neg_in;
                        if (rx_cfg_ff[`RX_UNIPOLAR]) begin
                            lcv_ff <= neg_in | (~rx_cfg_ff[`RX_VIOL_ONLY] & exz);
                        end else begin
                            lcv_ff <= bpv | (~rx_cfg_ff[`RX_VIOL_ONLY] & exz);
                        end
                        if (mark) begin
                            zero_run_ff <= 5'h00;
                        end else if (zero_run_ff != `ZERO_RUN_MAX) begin
                            zero_run_ff <= zero_run_ff + 5'd1;
                        end
                        if (~rx_cfg_ff[`RX_UNIPOLAR] & (pos_in ^ neg_in)) begin
                            last_pol_ff <= pos_in;
                            seen_mark_ff <= 1'b1;
                        end
                    end
                end
            end

            assign rx_frac = dl_opt_ff[`DL_RX_FRAC_SEL];
            assign rx_dma = dl_opt_ff[`DL_RX_DMA_SEL];
            assign tx_frac = dl_opt_ff[`DL_TX_FRAC_SEL];
            assign tx_dma = dl_opt_ff[`DL_TX_DMA_SEL];

            // Receive datalink pin routing.
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rx_pin_a_ff <= 1'b0;
                    rx_pin_b_ff <= 1'b0;
                end else if (rx_frac) begin
                    rx_pin_a_ff <= rx_pcm_bit[f];
                    rx_pin_b_ff <= rx_pcm_clock[f] &
                                   chan_hit(RX_CHAN_SEL, rx_channel_num[f*5 +: 5]);
                end else if (rx_dma) begin
                    rx_pin_a_ff <= rx_hdlc_data_irq[f] | rx_hdlc_eom_irq[f];
                    rx_pin_b_ff <= rx_hdlc_eom_irq[f];
                end else begin
                    rx_pin_a_ff <= rx_fdl_bit[f];
                    rx_pin_b_ff <= rx_fdl_clock[f];
                end
            end

            // Transmit pin directions and driven values.
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    svc_out_ff <= 1'b0;
                    svc_oe_ff <= 1'b0;
                    udr_out_ff <= 1'b0;
                    udr_oe_ff <= 1'b0;
                end else begin
                    svc_oe_ff <= tx_dma & ~tx_frac;
                    svc_out_ff <= tx_hdlc_service_irq[f];
                    udr_oe_ff <= ~tx_frac;
                    udr_out_ff <= tx_dma ? tx_hdlc_underrun_irq[f] : tx_fdl_clock[f];
                end
            end

            // Serial datalink capture and fractional insertion.
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fdl_clk_prev_ff <= 1'b0;
                    fdl_bit_ff <= 1'b0;
                    fdl_valid_ff <= 1'b0;
                    bclk_prev_ff <= 1'b0;
                    frac_bit_ff <= 1'b0;
                    line_bit_ff <= 1'b0;
                end else begin
                    fdl_clk_prev_ff <= tx_fdl_clock[f];
                    bclk_prev_ff <= bclk_s2_ff;
                    fdl_valid_ff <= 1'b0;
                    if (~tx_frac & ~tx_dma & tx_fdl_clock[f] & ~fdl_clk_prev_ff) begin
                        fdl_bit_ff <= tdat_s2_ff;
                        fdl_valid_ff <= 1'b1;
                    end
                    if (tx_frac & bclk_s2_ff & ~bclk_prev_ff) begin
                        frac_bit_ff <= tdat_s2_ff;
                    end
                    if (tx_frac & chan_hit(TX_CHAN_SEL, tx_channel_num[f*5 +: 5])) begin
                        line_bit_ff <= frac_bit_ff;
                    end else begin
                        line_bit_ff <= backplane_tx_pcm_in[f];
                    end
                end
            end

            // Enabled engine events for the shared interrupt.
            assign irq_contrib[f] =
                (dl_opt_ff[`DL_RX_DATA_IE] & (rx_hdlc_data_irq[f] | rx_hdlc_eom_irq[f])) |
                (dl_opt_ff[`DL_RX_EOM_IE] & rx_hdlc_eom_irq[f]) |
                (dl_opt_ff[`DL_TX_SVC_IE] & tx_hdlc_service_irq[f]) |
                (dl_opt_ff[`DL_TX_UDR_IE] & tx_hdlc_underrun_irq[f]);

            assign rx_recovered_pos[f] = rec_pos_ff;
            assign rx_recovered_neg[f] = rec_neg_ff;
            assign rx_bit_strobe[f] = strobe_ff;
            assign rx_line_code_violation[f] = lcv_ff;
            assign rx_dl_irq_pin[f] = rx_pin_a_ff;
            assign rx_dl_end_of_message_pin[f] = rx_pin_b_ff;
            assign tx_dl_service_pin_out[f] = svc_out_ff;
            assign tx_dl_service_pin_oe[f] = svc_oe_ff;
            assign tx_dl_underrun_pin_out[f] = udr_out_ff;
            assign tx_dl_underrun_pin_oe[f] = udr_oe_ff;
            assign tx_fdl_bit[f] = fdl_bit_ff;
            assign tx_fdl_bit_valid[f] = fdl_valid_ff;
            assign tx_line_bit[f] = line_bit_ff;
        end
    endgenerate
endmodule // framer_datalink_and_rx_line_config

// ==== design/framer_dl_regs.vh ====
// Register indices, field positions, reset values and line limits for the datalink block.
`ifndef FRAMER_DL_REGS_VH
`define FRAMER_DL_REGS_VH

// APB address width; byte address is four times the register index.
`define APB_ADDR_W 12

// Register indices as printed, one pair per framer.
`define DL_OPT_F1_IDX 10'h002
`define RX_CFG_F1_IDX 10'h003
`define DL_OPT_F2_IDX 10'h082
`define RX_CFG_F2_IDX 10'h083
`define DL_OPT_F3_IDX 10'h102
`define RX_CFG_F3_IDX 10'h103
`define DL_OPT_F4_IDX 10'h182
`define RX_CFG_F4_IDX 10'h183
`define FRAMER_IDX_STRIDE 10'h080

// Reset values.
`define DL_OPT_RESET 8'h00
`define RX_CFG_RESET 6'h00

// Datalink options fields.
`define DL_RX_DMA_SEL 7
`define DL_RX_FRAC_SEL 6
`define DL_TX_DMA_SEL 5
`define DL_TX_FRAC_SEL 4
`define DL_RX_DATA_IE 3
`define DL_RX_EOM_IE 2
`define DL_TX_SVC_IE 1
`define DL_TX_UDR_IE 0

// Receive line interface fields.
`define RX_VIOL_ONLY 5
`define RX_NEG_INV 4
`define RX_POS_INV 3
`define RX_UNIPOLAR 2
`define RX_FALL_EDGE 1
`define RX_RZ_SEL 0

// Excessive zero limits and the zero gaps that precede the violations of a substitution.
`define EXZ_AMI_LIMIT 5'd15
`define EXZ_B8ZS_LIMIT 5'd7
`define B8ZS_GAP_FIRST 5'd3
`define B8ZS_GAP_SECOND 5'd1
`define ZERO_RUN_MAX 5'h1f

// Default fractional channel map: only channel 24.
`define CHAN_SEL_DEFAULT 24'h800000

`endif
